//--- src/fbr_pkg.sv
package fbr_pkg;

    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int LVL_W      = $clog2(FIFO_DEPTH) + 1;
    localparam int AXI_AW     = 8;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_CFG    = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;

    // Configuration word
    localparam logic [15:0] CFG_RESET = 16'hbfcf;
    localparam logic [15:0] CFG_WMASK = 16'hbfcf;
    localparam int BIT_ASYNC = 15;
    localparam int BIT_HOLD  = 9;
    localparam int BIT_EARLY = 8;
    localparam int BIT_ORDER = 7;
    localparam int BIT_RISE  = 6;
    localparam int BIT_NOWRP = 3;
    localparam int BL_MSB    = 2;

    localparam logic [2:0] BL_4    = 3'h1;
    localparam logic [2:0] BL_8    = 3'h2;
    localparam logic [2:0] BL_16   = 3'h3;
    localparam logic [2:0] BL_CONT = 3'h7;

    localparam logic [ADDR_W-1:0] MASK_4    = 16'h0003;
    localparam logic [ADDR_W-1:0] MASK_8    = 16'h0007;
    localparam logic [ADDR_W-1:0] MASK_16   = 16'h000f;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 16'hffff;

    // Status word
    localparam int ST_ACTIVE  = 0;
    localparam int ST_WAIT    = 1;
    localparam int ST_CNT_LSB = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       two_clock_hold_select;
        logic       early_ready_release;
        logic       no_wrap_select;
        logic [2:0] burst_length_field;
    } fbr_cfg_type;

    typedef struct packed {
        logic              clk;
        logic              chip_sel_n;
        logic              out_en_n;
        logic              adv_n;
        logic [ADDR_W-1:0] addr;
    } fbr_pins_type;

endpackage

//--- src/fbr_burst_read.sv
// Function
// R1 - With two-clock hold set, each burst word stays on the data lines for two active edges.
// R2 - With two-clock hold clear, a new burst word is launched on every active edge.
// R3 - The host picks one-clock hold only when output delay plus its setup fits one period.
// R4 - With early release set, wait drops one data cycle before the data cycle holding valid data.
// R5 - With early release clear, wait drops in the same data cycle as the valid data.
// R6 - Only linear burst order exists and the host keeps the order bit at linear.
// R7 - The clock-edge bit selects the rising (default) or falling edge as the active edge.
// R8 - The active edge starts a burst, launches each word and changes the wait indicator.
// R9 - Without wrap, a fixed burst counts straight up across aligned boundaries.
// R10 - With wrap, a fixed burst counts modulo its length inside its aligned block.
// R11 - The length field selects 4, 8, 16 words or continuous for every array burst.
// R12 - A continuous burst always counts up and never wraps.
// R13 - A continuous burst keeps delivering words until the last address of the space.
// R14 - The host never combines latency code 2 with two-clock hold and early release.
// R15 - While output data is not yet valid wait stays asserted, and it drops once data is valid.
// R16 - The two-clock hold select sits in bit 9 of the configuration word.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.

////////////////////////////////////////////////////////////////////////////////
module fbr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       flush,
    input  wire logic                       in_valid,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            in_ready,
    output logic                            out_valid,
    output logic [WIDTH-1:0]                out_data,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic [PW:0]      nxt_count;
    logic             ready_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid && ready_ff;
    assign pop       = out_valid && out_ready;
    assign nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);
    assign in_ready  = ready_ff;
    assign out_valid = count_ff != '0;
    assign out_data  = mem_ff[rd_ptr_ff];
    assign level     = count_ff;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            ready_ff  <= 1'b1;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PW'(push);
            rd_ptr_ff <= rd_ptr_ff + PW'(pop);
            count_ff  <= nxt_count;
            ready_ff  <= nxt_count < (PW+1)'(DEPTH);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module fbr_burst_read
    import fbr_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                flash_clk,
    input  wire logic                flash_ce_n,
    input  wire logic                flash_oe_n,
    input  wire logic                flash_adv_n,
    input  wire logic [ADDR_W-1:0]   flash_addr,
    output logic [DATA_W-1:0]        dq_out,
    output logic                     dq_oe,
    output logic                     ready_wait,
    output logic                     ready_wait_oe,
    output logic [ADDR_W-1:0]        array_addr,
    output logic                     array_addr_valid,
    input  wire logic                array_addr_ready,
    input  wire logic [DATA_W-1:0]   array_data,
    input  wire logic                array_data_valid,
    output logic                     array_data_ready
);
    fbr_pins_type      pin_s1_ff;
    fbr_pins_type      pin_s2_ff;
    fbr_pins_type      pin_s3_ff;
    fbr_pins_type      pins_in;
    fbr_cfg_type       burst_cfg_ff;
    logic [15:0]       burst_read_config_ff;
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;
    logic              burst_ff;
    logic              adv_arm_ff;
    logic              phase_ff;
    logic [ADDR_W-1:0] start_addr_ff;
    logic [ADDR_W-1:0] idx_ff;
    logic [ADDR_W-1:0] sent_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic              addr_valid_ff;
    logic [DATA_W-1:0] dq_ff;
    logic              dq_oe_ff;
    logic              wait_ff;
    logic              wait_oe_ff;
    logic              active_edge;
    logic              selected;
    logic              start;
    logic              boundary;
    logic              pop;
    logic              cont;
    logic              fixed_done;
    logic              addr_take;
    logic              wr_go;
    logic              rd_go;
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] lin_addr;
    logic [ADDR_W-1:0] seq_addr;
    logic              fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic [LVL_W-1:0]  fifo_level;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign pins_in = '{flash_clk, flash_ce_n, flash_oe_n, flash_adv_n,
                       flash_addr};

    always_ff @(posedge aclk) begin
        pin_s1_ff <= pins_in;
        pin_s2_ff <= pin_s1_ff;
        pin_s3_ff <= pin_s2_ff;
    end

    assign active_edge = burst_read_config_ff[BIT_RISE] ?             // see R7
        (pin_s2_ff.clk && !pin_s3_ff.clk) : (!pin_s2_ff.clk && pin_s3_ff.clk);
    assign selected = !pin_s2_ff.chip_sel_n
        && !burst_read_config_ff[BIT_ASYNC];
    assign start    = active_edge && selected && !pin_s2_ff.adv_n     // see R8
        && (!burst_ff || adv_arm_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !arready_ff && !rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= wr_go;
            wready_ff  <= wr_go;
            if (awready_ff) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (s_axi_awaddr[AXI_AW-1:2] == OFS_CFG[AXI_AW-1:2]
                    || s_axi_awaddr[AXI_AW-1:2] == OFS_STATUS[AXI_AW-1:2])
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_read_config_ff <= CFG_RESET;
        end else if (awready_ff
                     && s_axi_awaddr[AXI_AW-1:2] == OFS_CFG[AXI_AW-1:2]) begin
            for (int b = 0; b < 2; b++) begin
                if (s_axi_wstrb[b]) begin
                    burst_read_config_ff[b*8 +: 8] <=
                        s_axi_wdata[b*8 +: 8] & CFG_WMASK[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= '0;
        end else begin
            arready_ff <= rd_go;
            if (arready_ff) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= RESP_OKAY;
                rdata_ff  <= '0;
                if (s_axi_araddr[AXI_AW-1:2] == OFS_CFG[AXI_AW-1:2]) begin
                    rdata_ff[15:0] <= burst_read_config_ff;
                end else if (s_axi_araddr[AXI_AW-1:2]
                             == OFS_STATUS[AXI_AW-1:2]) begin
                    rdata_ff[ST_ACTIVE] <= burst_ff;
                    rdata_ff[ST_WAIT]   <= wait_ff;
                    rdata_ff[ST_CNT_LSB +: ADDR_W] <= sent_ff;
                end else begin
                    rresp_ff <= RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst address sequence
    always_comb begin
        unique case (burst_cfg_ff.burst_length_field)                 // see R11
            BL_4:    mask = MASK_4;
            BL_8:    mask = MASK_8;
            BL_16:   mask = MASK_16;
            default: mask = ADDR_LAST;
        endcase
    end

    assign cont     = burst_cfg_ff.burst_length_field != BL_4
        && burst_cfg_ff.burst_length_field != BL_8
        && burst_cfg_ff.burst_length_field != BL_16;
    assign lin_addr = start_addr_ff + idx_ff;
    // Order is always linear, the order bit only stores            see R6
    assign seq_addr = (burst_cfg_ff.no_wrap_select || cont)          // see R12
        ? lin_addr                                                   // see R9
        : ((start_addr_ff & ~mask) | (lin_addr & mask));             // see R10
    assign addr_take  = addr_valid_ff && array_addr_ready;
    assign fixed_done = !cont && idx_ff == mask + 16'h0001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_ff      <= 1'b0;
            adv_arm_ff    <= 1'b1;
            burst_cfg_ff  <= '0;
            start_addr_ff <= '0;
            idx_ff        <= '0;
            addr_ff       <= '0;
            addr_valid_ff <= 1'b0;
        end else begin
            if (active_edge) begin
                adv_arm_ff <= pin_s2_ff.adv_n;
            end
            if (start) begin
                burst_ff      <= 1'b1;
                burst_cfg_ff  <= '{burst_read_config_ff[BIT_HOLD],
                                   burst_read_config_ff[BIT_EARLY],
                                   burst_read_config_ff[BIT_NOWRP],
                                   burst_read_config_ff[BL_MSB:0]};
                start_addr_ff <= pin_s2_ff.addr;
                addr_ff       <= pin_s2_ff.addr;
                addr_valid_ff <= 1'b1;
                idx_ff        <= 16'h0001;
            end else if (!selected) begin
                burst_ff      <= 1'b0;
                addr_valid_ff <= 1'b0;
            end else if (addr_take) begin
                if (fixed_done || (cont && addr_ff == ADDR_LAST)) begin // see R13
                    addr_valid_ff <= 1'b0;
                end else begin
                    addr_ff <= seq_addr;
                    idx_ff  <= idx_ff + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word buffer
    fbr_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (aclk),
        .rst_n     (aresetn),
        .flush     (start || !selected),
        .in_valid  (array_data_valid),
        .in_data   (array_data),
        .in_ready  (array_data_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop),
        .level     (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output data cycles and wait
    assign boundary = active_edge && burst_ff && !start && selected
        && (!burst_cfg_ff.two_clock_hold_select || phase_ff);   // see R1 R2 R16
    assign pop = boundary && fifo_valid && !pin_s2_ff.out_en_n
        && (cont || sent_ff != mask + 16'h0001)
        && (!burst_cfg_ff.early_ready_release || !wait_ff);   // see R4

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_ff <= 1'b0;
            sent_ff  <= '0;
            dq_ff    <= '0;
            wait_ff  <= 1'b0;
        end else if (start) begin
            phase_ff <= 1'b0;
            sent_ff  <= '0;
            wait_ff  <= 1'b1;                                         // see R15
        end else if (!burst_ff || !selected) begin
            wait_ff  <= 1'b0;
        end else if (boundary || active_edge) begin
            phase_ff <= !phase_ff;
            if (pop) begin
                dq_ff   <= fifo_data;                                 // see R8
                sent_ff <= sent_ff + 16'h0001;
            end
            if (boundary) begin
                if (!cont && sent_ff == mask + 16'h0001) begin
                    wait_ff <= 1'b0;
                end else if (burst_cfg_ff.early_ready_release) begin
                    wait_ff <= fifo_level == LVL_W'(pop);             // see R4
                end else begin
                    wait_ff <= !pop;                                  // see R5
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_oe_ff   <= 1'b0;
            wait_oe_ff <= 1'b0;
        end else begin
            dq_oe_ff   <= selected && !pin_s2_ff.out_en_n;
            wait_oe_ff <= !pin_s2_ff.chip_sel_n && !pin_s2_ff.out_en_n;
        end
    end

    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rresp      = rresp_ff;
    assign s_axi_rdata      = rdata_ff;
    assign dq_out           = dq_ff;
    assign dq_oe            = dq_oe_ff;
    assign ready_wait       = wait_ff;
    assign ready_wait_oe    = wait_oe_ff;
    assign array_addr       = addr_ff;
    assign array_addr_valid = addr_valid_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_two_clock_hold: assert property (                             // see R1
        pop && burst_cfg_ff.two_clock_hold_select |=> !pop)
        else $error("two-clock hold word replaced after one edge");
    a_one_clock_word: assert property (                             // see R2
        pop && !burst_cfg_ff.two_clock_hold_select
        |=> dq_out == $past(fifo_data))
        else $error("one-clock hold word not launched");
    a_wait_early: assert property (                                 // see R4
        boundary && burst_cfg_ff.early_ready_release && fifo_level > 1
        && (cont || sent_ff + 16'h0001 < mask + 16'h0001) |=> !ready_wait)
        else $error("early wait release missed");
    a_early_announced: assert property (                            // see R4
        pop && burst_cfg_ff.early_ready_release |-> !ready_wait)
        else $error("early mode word launched without prior release");
    a_wait_with_data: assert property (                             // see R5
        boundary && !burst_cfg_ff.early_ready_release && !pop
        && (cont || sent_ff != mask + 16'h0001) |=> ready_wait)
        else $error("wait released without data");
    a_edge_polarity: assert property (                              // see R7
        active_edge |-> pin_s2_ff.clk == burst_read_config_ff[BIT_RISE])
        else $error("active edge of wrong polarity");
    a_launch_on_edge: assert property (                             // see R8
        $changed(sent_ff) && !start && burst_ff |-> $past(active_edge))
        else $error("word launched off the active edge");
    a_nowrap_step: assert property (                                // see R9
        addr_take && (burst_cfg_ff.no_wrap_select || cont) && !start
        ##1 addr_valid_ff && !start |-> addr_ff == $past(addr_ff) + 16'h0001)
        else $error("linear burst did not step by one");
    a_wrap_block: assert property (                                 // see R10
        addr_take && !cont && !burst_cfg_ff.no_wrap_select && !start
        |=> (addr_ff & ~mask) == ($past(addr_ff) & ~mask))
        else $error("wrapped burst left its block");
    a_fixed_length: assert property (                               // see R11
        !cont |-> sent_ff <= mask + 16'h0001)
        else $error("fixed burst delivered too many words");
    a_pending_wait: assert property (                               // see R15
        start |=> ready_wait)
        else $error("wait not asserted at burst start");

    c_hold_two:  cover property (pop ##[1:8] pop);
    c_wrap_four: cover property (addr_take && !cont
        && !burst_cfg_ff.no_wrap_select && addr_ff[1:0] == 2'h3);
    c_cont:      cover property (pop && cont);
    c_stall:     cover property (!array_data_ready && array_data_valid);
endmodule

//--- dv/fbr_host_model.sv
////////////////////////////////////////
module fbr_host_model
    import fbr_pkg::*;
(
    input  wire logic              aclk,
    output logic                   flash_clk,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_adv_n,
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic              ready_wait
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        flash_clk = 1'b0;
        flash_ce_n = 1'b1;
        flash_oe_n = 1'b1;
        flash_adv_n = 1'b1;
        flash_addr = 16'h0000;
    end
    // Clock stands still between bursts; toggle up to the active level
    task automatic step(input logic rise);
        do begin
            flash_clk <= ~flash_clk;
            repeat (8) @(posedge aclk);
        end while (flash_clk !== rise);
    endtask
    // Collect words at data-cycle boundaries, as wait announces them
    task automatic burst(input logic rise, two, early,
                         input logic [15:0] start, input int n,
                         output logic [15:0] w [$]);
        int   e = 0;
        logic pw = 1'b1;
        w = {};
        flash_addr <= start;
        flash_ce_n <= 1'b0;
        flash_oe_n <= 1'b0;
        flash_adv_n <= 1'b0;
        repeat (8) @(posedge aclk);
        step(rise);
        flash_adv_n <= 1'b1;
        flash_addr <= ~start;
        while (w.size() < n && e < 80) begin
            step(rise);
            e++;
            if (!two || e % 2 == 0) begin
                if ((early ? pw : ready_wait) === 1'b0) w.push_back(dq_out);
                pw = ready_wait;
            end
        end
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule

//--- dv/test_fbr_burst_read.sv
////////////////////////////////////////
module test_fbr_burst_read
    import fbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        fclk, ce_n, oe_n, adv_n, rwait, a_av, a_dr;
    logic [15:0] faddr, dq, a_addr, a_data = 16'h0;
    logic        a_ar = 1'b0, a_dv = 1'b0, saw_full = 1'b0;
    logic        dq_en, wait_en, saw_en = 1'b0;
    logic [15:0] aq [$];
    int          n_fail = 0, compares = 0;
    logic [31:0] tab [5] = '{32'hf2000304, 32'h22000204, 32'h44000508,
                             32'ha6000e10, 32'h2efffa06};
    always #50 aclk = ~aclk;
    fbr_burst_read dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_clk(fclk),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_adv_n(adv_n),
        .flash_addr(faddr), .dq_out(dq), .dq_oe(dq_en), .ready_wait(rwait),
        .ready_wait_oe(wait_en), .array_addr(a_addr), .array_addr_valid(a_av),
        .array_addr_ready(a_ar), .array_data(a_data),
        .array_data_valid(a_dv), .array_data_ready(a_dr));
    fbr_host_model host (.aclk(aclk), .flash_clk(fclk), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_adv_n(adv_n), .flash_addr(faddr),
        .dq_out(dq), .ready_wait(rwait));
    // Array answers in order, stalls its address side every other cycle
    always @(posedge aclk) begin
        if (a_dr === 1'b0) saw_full <= 1'b1;
        if (dq_en && wait_en) saw_en <= 1'b1;
        if (a_dv && a_dr) void'(aq.pop_front());
        if (a_av && a_ar) aq.push_back(a_addr);
        if (ce_n) aq.delete();
        a_ar <= ~a_ar;
        a_dv <= (aq.size() != 0);
        a_data <= (aq.size() != 0) ? aq[0] ^ 16'h5a5a : ~a_data;
    end
    ////////////////////////////////////////
    function automatic logic [15:0] nxt(logic [15:0] a, logic [2:0] l,
                                        logic nw);
        logic [15:0] m;
        m = (l == BL_4) ? MASK_4 : (l == BL_8) ? MASK_8 : MASK_16;
        if (nw || l == BL_CONT) return a + 16'h0001;
        return (a & ~m) | ((a + 16'h0001) & m);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic close_out;
        $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        close_out();
    end
    ////////////////////////////////////////
    initial begin
        logic [31:0] d, t, c;
        logic [1:0]  r;
        logic [15:0] w [$];
        logic [15:0] a;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(OFS_CFG, d, r);
        chk("cfg_reset", {16'h0, CFG_RESET}, d);
        axi_wr(8'h08, 32'h1234, r);
        chk("wr_unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h08, d, r);
        chk("rd_unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("rd_unmapped_data", 32'h0, d);
        $display("Test registers done");
        foreach (tab[i]) begin
            t = tab[i];
            c = {16'h0, 2'h0, 3'h3, 1'b1, t[31:30], 1'b1, t[29], 2'h0,
                 t[28], t[27:25]};
            axi_wr(OFS_CFG, c, r);
            chk("cfg_wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
            axi_rd(OFS_CFG, d, r);
            chk("cfg_readback", c, d);
            host.burst(t[29], t[31], t[30], t[23:8], t[7:0], w);
            chk("word_count", {24'h0, t[7:0]}, w.size());
            a = t[23:8];
            foreach (w[k]) begin
                chk("burst_word", {16'h0, a ^ 16'h5a5a}, {16'h0, w[k]});
                a = nxt(a, t[27:25], t[28]);
            end
            $display("Test burst %0d done", i);
        end
        chk("fifo_refused", 32'h1, {31'h0, saw_full});
        axi_rd(OFS_STATUS, d, r);
        chk("status_resp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("status_sent", 32'(t[7:0]) << ST_CNT_LSB, d);
        chk("pins_driven", 32'h1, {31'h0, saw_en});
        chk("pins_released", 32'h0, {30'h0, dq_en, wait_en});
        $display("Test status done");
        close_out();
    end
endmodule
